// ### sadc_pkg.sv
// Shared constants of the serial converter control link: command byte layout,
// frame lengths, power codes and the host's serial clock divider.
// Assumes both ends and the bench import this package.
//
// Notes on behaviour
// - Eight-clock transfers; three make one conversion.
// - Host sends command byte in first eight clocks.
// - Channel bits known: set mux, start acquiring.
// - Three clocks later: hold and start converting.
// - Sixteen following clocks, one decision each.
// - Data input ignored until a high start bit.
// - Byte: start, channel, unused, mode, power bits.
// - Channel bits and mode bit steer the mux.
// - Single-ended codes route one input against common.
// - Differential codes route fixed input pairs.
// - Mode high single-ended, low differential.
// - Power bits both high: always powered.
// - Power bits low: sleep between, instant wake.
// - Unsigned result, 65536 steps over reference.
// - Host supplies the serial clock.
// - Power code one-zero selects internal clock mode.
// - Busy high one period after last command bit.
// - Decisions shifted out MSB first on falling edges.
// - Chip select high floats data and busy outputs.
package sadc_pkg;
	// ------------------------------------------------------------
	// Command byte layout
	// ------------------------------------------------------------
	localparam int CMD_W = 8;
	localparam int CMD_START_BIT = 7;
	localparam int CMD_CH_HI = 6;
	localparam int CMD_CH_LO = 4;
	localparam int CMD_MODE_BIT = 2;
	localparam int CMD_PD_HI = 1;
	localparam int CMD_PD_LO = 0;
	localparam logic [1:0] PD_SLEEP = 2'h0;
	localparam logic [1:0] PD_RESERVED = 2'h1;
	localparam logic [1:0] PD_INT_CLK = 2'h2;
	localparam logic [1:0] PD_ALWAYS_ON = 2'h3;

	// ------------------------------------------------------------
	// Frame and conversion lengths in serial clocks
	// ------------------------------------------------------------
	localparam int RES_W = 16;
	localparam logic [3:0] ACQ_START_BITS = 4'h5;
	localparam logic [3:0] CMD_BITS = 4'h8;
	localparam logic [4:0] CONV_FALLS = 5'h10;
	localparam logic [4:0] FRAME_CLKS = 5'h18;
	localparam logic [4:0] FIRST_DATA_RISE = 5'h0A;
	localparam logic [2:0] NEG_SHARED = 3'h4;

	// ------------------------------------------------------------
	// Host serial clock divider (host end only)
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCLK_HALF_NS = 15;
	localparam logic [1:0] SCLK_HALF_CYC = 2'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : sadc_pkg

// ### sadc_link_if.sv
// Serial link between the converter end and the host end.
// Assumes a bench resolves the three-state pins from the enables.
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
	logic host_serial_clock;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic busy;
	logic busy_oe;

	modport dev (
		input host_serial_clock, cs_n, din,
		output dout, dout_oe, busy, busy_oe
	);
	modport host (
		output host_serial_clock, cs_n, din,
		input dout, dout_oe, busy, busy_oe
	);
endinterface : sadc_link_if
`default_nettype wire

// ### sadc_dev.sv
// Converter end: command decode, multiplexer, sample/hold and SAR sequencing.
// Runs on the host serial clock; result and status cross into i_clk.
// Assumes analog input codes are held steady around the hold edge.
`timescale 1ns/1ps
`default_nettype none
module sadc_dev
	import sadc_pkg::*;
(
	sadc_link_if.dev link,
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [4*RES_W-1:0] i_analog_inputs,
	input wire logic [RES_W-1:0] i_shared_negative_input,
	output logic [RES_W-1:0] o_result,
	output logic o_result_valid,
	output logic o_acquiring,
	output logic o_powered,
	output logic o_int_clk_mode
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Positive and negative mux legs; negative index 4 is the shared pin
	function automatic logic [5:0] sadc_route(input logic [2:0] code, input logic sgl);
		logic [2:0] pos;
		logic [2:0] neg;
		pos = 3'h0;
		neg = NEG_SHARED;
		unique case (code)
			3'h1: begin pos = 3'h0; neg = 3'h1; end
			3'h5: begin pos = 3'h1; neg = 3'h0; end
			3'h2: begin pos = 3'h2; neg = 3'h3; end
			3'h6: begin pos = 3'h3; neg = 3'h2; end
			default: begin pos = 3'h0; neg = 3'h1; end
		endcase
		if (sgl) begin
			neg = NEG_SHARED;
		end
		return {pos, neg};
	endfunction : sadc_route

	// One successive-approximation decision on bit b
	function automatic logic [RES_W-1:0] sadc_sar(input logic [RES_W-1:0] approx,
			input logic [RES_W-1:0] held, input logic [3:0] b);
		logic [RES_W-1:0] trial;
		trial = approx | (16'h0001 << b);
		return (held >= trial) ? trial : approx;
	endfunction : sadc_sar

	// ------------------------------------------------------------
	// Link-side reset
	// ------------------------------------------------------------
	// The serial clock may stop, so reset takes hold at once and lets go on clock rises
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge link.host_serial_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Command shift on rising edges
	// ------------------------------------------------------------
	logic in_cmd_q;
	logic [3:0] bit_cnt_q;
	logic [CMD_W-1:0] cmd_q;
	logic [CMD_W-1:0] cmd_d;
	logic acq_q;
	logic conv_go_q;
	logic [2:0] pos_sel_q;
	logic [2:0] neg_sel_q;
	logic [RES_W-1:0] held_q;
	logic [RES_W-1:0] pos_val;
	logic [RES_W-1:0] neg_val;
	logic [5:0] route;
	logic [5:0] route_acq;

	assign cmd_d = {cmd_q[CMD_W-2:0], link.din};
	// Channel bits sit one place lower at the fifth rise than at the sixth
	assign route_acq = sadc_route(cmd_q[CMD_CH_HI-4:CMD_CH_LO-4], 1'b1);
	assign route = sadc_route(cmd_q[CMD_CH_HI-3:CMD_CH_LO-3], link.din);
	assign pos_val = i_analog_inputs[pos_sel_q*RES_W +: RES_W];
	assign neg_val = (neg_sel_q == NEG_SHARED) ? i_shared_negative_input :
		i_analog_inputs[neg_sel_q[1:0]*RES_W +: RES_W];

	// Start detect and byte assembly; select high clears at once, even with no clock
	always_ff @(posedge link.host_serial_clock or posedge link.cs_n) begin
		if (link.cs_n) begin
			in_cmd_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			cmd_q <= 8'h00;
		end else if (!in_cmd_q) begin
			if (link.din) begin
				in_cmd_q <= 1'b1;
				bit_cnt_q <= 4'h1;
				cmd_q <= 8'h01;
			end
		end else begin
			cmd_q <= cmd_d;
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (bit_cnt_q == CMD_BITS - 4'h1) begin
				in_cmd_q <= 1'b0;
			end
		end
	end

	// Mux setting, acquisition and hold
	always_ff @(posedge link.host_serial_clock or posedge link.cs_n) begin
		if (link.cs_n) begin
			acq_q <= 1'b0;
			conv_go_q <= 1'b0;
			pos_sel_q <= 3'h0;
			neg_sel_q <= NEG_SHARED;
			held_q <= 16'h0000;
		end else begin
			conv_go_q <= 1'b0;
			if (in_cmd_q && bit_cnt_q == ACQ_START_BITS - 4'h1) begin
				acq_q <= 1'b1;
				pos_sel_q <= route_acq[5:3];
				neg_sel_q <= route_acq[2:0];
			end
			// Mode bit lands one clock into acquisition and finalises the legs
			if (in_cmd_q && bit_cnt_q == ACQ_START_BITS) begin
				pos_sel_q <= route[5:3];
				neg_sel_q <= route[2:0];
			end
			if (in_cmd_q && bit_cnt_q == CMD_BITS - 4'h1) begin
				acq_q <= 1'b0;
				conv_go_q <= 1'b1;
				// Negative difference clips to code zero
				held_q <= (pos_val > neg_val) ? pos_val - neg_val : 16'h0000;
			end
		end
	end

	// Power and clock mode; reserved code leaves both alone
	logic always_on_q;
	logic int_clk_q;
	always_ff @(posedge link.host_serial_clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			always_on_q <= 1'b0;
			int_clk_q <= 1'b0;
		end else if (in_cmd_q && !link.cs_n && bit_cnt_q == CMD_BITS - 4'h1) begin
			unique case (cmd_d[CMD_PD_HI:CMD_PD_LO])
				PD_ALWAYS_ON: begin always_on_q <= 1'b1; int_clk_q <= 1'b0; end
				PD_INT_CLK: begin always_on_q <= 1'b1; int_clk_q <= 1'b1; end
				PD_SLEEP: always_on_q <= 1'b0;
				PD_RESERVED: always_on_q <= always_on_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Conversion on falling edges
	// ------------------------------------------------------------
	logic [4:0] fall_cnt_q;
	logic [RES_W-1:0] approx_q;
	logic dout_q;
	logic busy_q;
	logic [RES_W-1:0] res_q;
	logic res_tgl_q;
	logic [3:0] out_idx;
	assign out_idx = 4'(CONV_FALLS - fall_cnt_q);

	// Busy for one period, then one decision out per falling edge
	always_ff @(negedge link.host_serial_clock or posedge link.cs_n) begin
		if (link.cs_n) begin
			fall_cnt_q <= 5'h00;
			approx_q <= 16'h0000;
			dout_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (conv_go_q) begin
			busy_q <= 1'b1;
			dout_q <= 1'b0;
			fall_cnt_q <= 5'h01;
			approx_q <= sadc_sar(16'h0000, held_q, 4'hF);
		end else begin
			busy_q <= 1'b0;
			if (fall_cnt_q != 5'h00 && fall_cnt_q <= CONV_FALLS) begin
				dout_q <= approx_q[out_idx];
				fall_cnt_q <= fall_cnt_q + 5'h01;
				if (fall_cnt_q != CONV_FALLS) begin
					approx_q <= sadc_sar(approx_q, held_q, out_idx - 4'h1);
				end
			end else begin
				// Clocks past the result shift out zeros
				dout_q <= 1'b0;
				fall_cnt_q <= 5'h00;
			end
		end
	end

	// Finished word is published with a toggle for the system side
	always_ff @(negedge link.host_serial_clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			res_q <= 16'h0000;
			res_tgl_q <= 1'b0;
		end else if (!link.cs_n && fall_cnt_q == CONV_FALLS && !conv_go_q) begin
			res_q <= approx_q;
			res_tgl_q <= ~res_tgl_q;
		end
	end

	// Frame activity; select high drops it, as no clock edge follows a frame
	logic powered_q;
	always_ff @(posedge link.host_serial_clock or posedge link.cs_n) begin
		if (link.cs_n) begin
			powered_q <= 1'b0;
		end else begin
			powered_q <= in_cmd_q || link.din || fall_cnt_q != 5'h00 || conv_go_q;
		end
	end

	// Enables follow chip select directly; a stopped clock could not release them
	assign link.dout = dout_q;
	assign link.busy = busy_q;
	assign link.dout_oe = !link.cs_n;
	assign link.busy_oe = !link.cs_n;

	// ------------------------------------------------------------
	// Crossing into i_clk
	// ------------------------------------------------------------
	logic [2:0] tgl_s_q;
	logic [1:0] acq_s_q;
	logic [1:0] pwr_s_q;
	logic [1:0] icm_s_q;
	logic [1:0] aon_s_q;
	always_ff @(posedge i_clk) begin
		tgl_s_q <= {tgl_s_q[1:0], res_tgl_q};
		acq_s_q <= {acq_s_q[0], acq_q};
		pwr_s_q <= {pwr_s_q[0], powered_q};
		icm_s_q <= {icm_s_q[0], int_clk_q};
		aon_s_q <= {aon_s_q[0], always_on_q};
	end

	// Word is read only after its toggle has settled through the synchroniser
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_result <= 16'h0000;
			o_result_valid <= 1'b0;
			o_acquiring <= 1'b0;
			o_powered <= 1'b0;
			o_int_clk_mode <= 1'b0;
		end else begin
			o_result_valid <= tgl_s_q[2] ^ tgl_s_q[1];
			if (tgl_s_q[2] ^ tgl_s_q[1]) begin
				o_result <= res_q;
			end
			o_acquiring <= acq_s_q[1];
			o_powered <= pwr_s_q[1] || aon_s_q[1];
			o_int_clk_mode <= icm_s_q[1];
		end
	end
endmodule : sadc_dev
`default_nettype wire

// ### sadc_host.sv
// Host end: makes the serial clock from i_clk, sends command bytes and
// collects 16-bit results, streaming at 24 clocks per conversion.
// Assumes the converter end sits on the same link interface.
`timescale 1ns/1ps
`default_nettype none
module sadc_host
	import sadc_pkg::*;
(
	sadc_link_if.host link,
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [2:0] i_channel_select,
	input wire logic i_input_mode_select,
	input wire logic [1:0] i_power_mode_bits,
	output logic o_ready,
	output logic o_active,
	output logic o_link_busy,
	output logic [RES_W-1:0] o_result,
	output logic o_result_valid
);
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_SETUP = 2'b01,
		SADC_RUN = 2'b10
	} sadc_state_t;

	sadc_state_t state_q;
	logic [1:0] half_q;
	logic tick;
	logic sclk_q;
	logic cs_n_q;
	logic din_q;
	logic [4:0] rise_q;
	logic [CMD_W-1:0] cmd_q;
	logic [CMD_W-1:0] pend_cmd_q;
	logic pend_q;
	logic lsb_due_q;
	logic tail_q;
	logic [RES_W-1:0] shift_q;
	logic [1:0] dout_s_q;
	logic [1:0] busy_s_q;
	logic [CMD_W-1:0] new_cmd;

	// Bit 3 is sent low and is ignored at the far end
	assign new_cmd = {1'b1, i_channel_select, 1'b0, i_input_mode_select, i_power_mode_bits};
	assign tick = (half_q == SCLK_HALF_CYC - 2'h1);

	// ------------------------------------------------------------
	// Pin inputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		dout_s_q <= {dout_s_q[0], link.dout};
		busy_s_q <= {busy_s_q[0], link.busy && link.busy_oe};
	end

	// ------------------------------------------------------------
	// Request queue of one command
	// ------------------------------------------------------------
	// Slot refills only once empty; o_ready stays low over that gap
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pend_q <= 1'b0;
			pend_cmd_q <= 8'h00;
		end else if (i_start && !pend_q) begin
			pend_q <= 1'b1;
			pend_cmd_q <= new_cmd;
		end else if (pend_q && ((state_q == SADC_IDLE) ||
				(tick && state_q == SADC_RUN && sclk_q && rise_q == FRAME_CLKS))) begin
			pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Serial clock divider
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn || state_q == SADC_IDLE) begin
			half_q <= 2'h0;
		end else begin
			half_q <= tick ? 2'h0 : half_q + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	// Data changes on the low-going edge so it is steady at the rise
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q <= SADC_IDLE;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			din_q <= 1'b0;
			rise_q <= 5'h00;
			cmd_q <= 8'h00;
			lsb_due_q <= 1'b0;
			tail_q <= 1'b0;
			shift_q <= 16'h0000;
			o_result <= 16'h0000;
			o_result_valid <= 1'b0;
		end else begin
			o_result_valid <= 1'b0;
			unique case (state_q)
				SADC_IDLE: begin
					// Divider is held in idle, so a frame opens without waiting for a tick
					if (pend_q) begin
						cmd_q <= pend_cmd_q;
						din_q <= pend_cmd_q[CMD_START_BIT];
						cs_n_q <= 1'b0;
						rise_q <= 5'h00;
						tail_q <= 1'b0;
						state_q <= SADC_SETUP;
					end
				end
				SADC_SETUP: begin
					if (tick) begin
						state_q <= SADC_RUN;
					end
				end
				SADC_RUN: begin
					if (tick && !sclk_q) begin
						sclk_q <= 1'b1;
						rise_q <= rise_q + 5'h01;
						// Synchronised data settled a half period after the fall
						if (rise_q + 5'h01 >= FIRST_DATA_RISE) begin
							shift_q <= {shift_q[RES_W-2:0], dout_s_q[1]};
						end
						if (rise_q == 5'h00 && lsb_due_q) begin
							o_result <= {shift_q[RES_W-2:0], dout_s_q[1]};
							o_result_valid <= 1'b1;
							lsb_due_q <= 1'b0;
						end
					end else if (tick && sclk_q) begin
						sclk_q <= 1'b0;
						if (tail_q) begin
							// Trailing clock only fetched the last bit
							cs_n_q <= 1'b1;
							din_q <= 1'b0;
							state_q <= SADC_IDLE;
						end else if (rise_q == FRAME_CLKS) begin
							rise_q <= 5'h00;
							lsb_due_q <= 1'b1;
							tail_q <= !pend_q;
							cmd_q <= pend_q ? pend_cmd_q : 8'h00;
							din_q <= pend_q && pend_cmd_q[CMD_START_BIT];
						end else begin
							// Zeros after the byte keep the far end from restarting
							din_q <= (rise_q < 5'(CMD_BITS)) &&
								cmd_q[3'(CMD_W - 1 - int'(rise_q))];
						end
					end
				end
				default: state_q <= SADC_IDLE;
			endcase
		end
	end

	// Registered status outputs
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_ready <= 1'b0;
			o_active <= 1'b0;
			o_link_busy <= 1'b0;
		end else begin
			o_ready <= !pend_q && !i_start;
			o_active <= (state_q != SADC_IDLE);
			o_link_busy <= busy_s_q[1];
		end
	end

	assign link.host_serial_clock = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.din = din_q;
endmodule : sadc_host
`default_nettype wire

// ### sadc_link_assertions.sv
// Checker for the serial converter link: framing, busy pulse, enables and clock shape.
// Assumes the bench wires in the link interface signals and the i_clk domain reset.
`timescale 1ns/1ps
`default_nettype none
module sadc_link_assertions (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic host_serial_clock,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic busy,
	input wire logic busy_oe
);
	// ------------------------------------------------------------
	// Frame position in serial clock rises
	// ------------------------------------------------------------
	logic [4:0] rise_q;
	// Select is seen only at clock edges, so a select rise mid-frame stays visible
	always_ff @(posedge host_serial_clock or negedge i_resetn) begin
		if (!i_resetn || cs_n) begin
			rise_q <= 5'h00;
		end else if ((rise_q == 5'h00 || rise_q == 5'h18) && din) begin
			rise_q <= 5'h01;
		end else if (rise_q == 5'h18) begin
			rise_q <= 5'h00;
		end else if (rise_q != 5'h00) begin
			rise_q <= rise_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_enable_follows_select;
		@(posedge i_clk) disable iff (!i_resetn) (dout_oe == !cs_n) && (busy_oe == !cs_n);
	endproperty
	a_enable_follows_select: assert property (p_enable_follows_select)
		else $error("output enable differs from chip select");
	property p_busy_one_period;
		@(posedge host_serial_clock) disable iff (!i_resetn) !cs_n |-> (busy == (rise_q == 5'h08));
	endproperty
	a_busy_one_period: assert property (p_busy_one_period)
		else $error("busy not high for exactly the period after the command byte");
	property p_select_held_in_frame;
		@(posedge i_clk) disable iff (!i_resetn) rise_q inside {[5'h01:5'h17]} |-> !cs_n;
	endproperty
	a_select_held_in_frame: assert property (p_select_held_in_frame)
		else $error("chip select released inside a frame");
	property p_unused_bit_low;
		@(posedge host_serial_clock) disable iff (!i_resetn) rise_q == 5'h04 |-> !din;
	endproperty
	a_unused_bit_low: assert property (p_unused_bit_low)
		else $error("unused command bit not sent low");
	property p_pad_after_byte;
		@(posedge host_serial_clock) disable iff (!i_resetn) rise_q inside {[5'h08:5'h17]} |-> !din;
	endproperty
	a_pad_after_byte: assert property (p_pad_after_byte)
		else $error("data input not low after the command byte");
	property p_dout_low_before_msb;
		@(posedge host_serial_clock) disable iff (!i_resetn)
		!cs_n && rise_q inside {[5'h02:5'h08]} |-> !dout;
	endproperty
	a_dout_low_before_msb: assert property (p_dout_low_before_msb)
		else $error("data output not low before the first decision");
	property p_clock_idle_low;
		@(posedge i_clk) disable iff (!i_resetn) cs_n [*4] |-> !host_serial_clock;
	endproperty
	a_clock_idle_low: assert property (p_clock_idle_low)
		else $error("serial clock not idle low while deselected");
	property p_clock_high_time;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(host_serial_clock) |-> host_serial_clock [*3] ##1 !host_serial_clock;
	endproperty
	a_clock_high_time: assert property (p_clock_high_time)
		else $error("serial clock high phase not three cycles");
endmodule : sadc_link_assertions
`default_nettype wire

// ### sar_adc_serial_control_test.sv
// Bench for the serial converter link: host end and converter end face each other.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_control_test
	import sadc_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_resetn;
	logic start = 1'b0;
	logic mode = 1'b1;
	logic [2:0] chan = 3'h1;
	logic [1:0] pd = 2'h3;
	logic [63:0] ain = 64'hC3504E209C401388;
	logic [15:0] neg = 16'h0FA0;
	logic ready, active, link_busy, h_val, d_val, acq, powered, int_mode;
	logic [15:0] h_res, d_res, e;
	logic busy_d = 1'b0;
	logic [15:0] hq [$];
	logic [15:0] dq [$];
	int n_mismatch = 0;
	int tests_run = 0;
	int busy_cnt = 0;
	int b;

	always #2.5 i_clk = ~i_clk;

	sadc_link_if sadc_link_if_i ();
	sadc_dev sadc_dev_i (.link(sadc_link_if_i.dev), .i_clk(i_clk), .i_resetn(i_resetn),
		.i_analog_inputs(ain), .i_shared_negative_input(neg), .o_result(d_res),
		.o_result_valid(d_val), .o_acquiring(acq), .o_powered(powered), .o_int_clk_mode(int_mode));
	sadc_host sadc_host_i (.link(sadc_link_if_i.host), .i_clk(i_clk), .i_resetn(i_resetn),
		.i_start(start), .i_channel_select(chan), .i_input_mode_select(mode),
		.i_power_mode_bits(pd), .o_ready(ready), .o_active(active), .o_link_busy(link_busy),
		.o_result(h_res), .o_result_valid(h_val));
	sadc_link_assertions sadc_link_assertions_i (.i_clk(i_clk), .i_resetn(i_resetn),
		.host_serial_clock(sadc_link_if_i.host_serial_clock), .cs_n(sadc_link_if_i.cs_n),
		.din(sadc_link_if_i.din), .dout(sadc_link_if_i.dout), .dout_oe(sadc_link_if_i.dout_oe),
		.busy(sadc_link_if_i.busy), .busy_oe(sadc_link_if_i.busy_oe));

	// Collect finished results mid-cycle and count busy pulses seen by the host
	always @(negedge i_clk) begin
		if (h_val === 1'b1) hq.push_back(h_res);
		if (d_val === 1'b1) dq.push_back(d_res);
		if (link_busy === 1'b1 && busy_d !== 1'b1) busy_cnt++;
		busy_d <= link_busy;
	end

	// ------------------------------------------------------------
	// Compare, expectation and access tasks
	// ------------------------------------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit
	// Difference code clipped at zero; code index is {bit5, bit6}
	function automatic logic [15:0] expect_code(input logic [2:0] c, input logic m);
		logic [1:0] p;
		logic [16:0] d;
		p = {c[1], c[2]};
		d = {1'b0, ain[16*p +: 16]} - {1'b0, (m ? neg : ain[16*(p ^ 2'h1) +: 16])};
		return d[16] ? 16'h0000 : d[15:0];
	endfunction : expect_code
	task automatic issue(input logic [2:0] c, input logic m, input logic [1:0] p);
		int t;
		t = 0;
		@(negedge i_clk);
		while (ready !== 1'b1 && t < 2000) begin
			@(negedge i_clk);
			t++;
		end
		chan = c;
		mode = m;
		pd = p;
		start = 1'b1;
		@(negedge i_clk);
		start = 1'b0;
	endtask : issue
	// Missing results show up as unknown values and so as mismatches
	task automatic take(input logic [15:0] exp);
		int t;
		t = 0;
		while ((hq.size() == 0 || dq.size() == 0) && t < 4000) begin
			@(negedge i_clk);
			t++;
		end
		chk_val(hq.size() > 0 ? hq.pop_front() : 16'hXXXX, exp);
		chk_val(dq.size() > 0 ? dq.pop_front() : 16'hXXXX, exp);
	endtask : take
	task automatic wait_acq(input logic lvl);
		int t;
		t = 0;
		while (acq !== lvl && t < 2000) begin
			@(negedge i_clk);
			t++;
		end
	endtask : wait_acq
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		// Reset falls after time zero so the link side sees a real edge
		#1 i_resetn = 1'b0;
		repeat (20) @(negedge i_clk);
		i_resetn = 1'b1;
		// Channel codes 1, 5, 2 and 6 in both input modes, one busy pulse each
		for (int m = 1; m >= 0; m--) begin
			for (int i = 0; i < 4; i++) begin
				b = busy_cnt;
				issue(3'(12'hCA9 >> (3 * i)), m[0], 2'h3);
				take(expect_code(3'(12'hCA9 >> (3 * i)), m[0]));
				chk_val(16'(busy_cnt), 16'(b + 1));
				chk_bit(acq, 1'b0);
			end
		end
		$display("test mux done");
		// Power codes in turn; clock mode survives sleep and the reserved code
		for (int k = 0; k < 5; k++) begin
			issue(3'h1, 1'b1, 2'(10'h31B >> (2 * k)));
			take(expect_code(3'h1, 1'b1));
			repeat (20) @(negedge i_clk);
			chk_bit(int_mode, 1'(5'h0E >> k));
			chk_bit(powered, 1'(5'h17 >> k));
			chk_bit(active, 1'b0);
			chk_bit(ready, 1'b1);
		end
		$display("test power done");
		// Second request queued during the first streams back to back
		issue(3'h1, 1'b1, 2'h3);
		issue(3'h6, 1'b0, 2'h3);
		take(expect_code(3'h1, 1'b1));
		take(expect_code(3'h6, 1'b0));
		$display("test stream done");
		// Full-scale and below-zero differences
		ain[15:0] = 16'hFFFF;
		neg = 16'h0000;
		issue(3'h1, 1'b1, 2'h3);
		take(16'hFFFF);
		ain[15:0] = 16'h0000;
		neg = 16'h0FA0;
		issue(3'h1, 1'b1, 2'h3);
		take(16'h0000);
		$display("test clip done");
		// Input moved after the hold edge must not reach the result
		ain[15:0] = 16'h2710;
		e = expect_code(3'h1, 1'b1);
		issue(3'h1, 1'b1, 2'h3);
		wait_acq(1'b1);
		chk_bit(acq, 1'b1);
		wait_acq(1'b0);
		ain[15:0] = 16'hF000;
		take(e);
		$display("test hold done");
		stop_test();
	end

	// Whole run needs a few thousand cycles; this bound only cuts a hang short
	initial begin
		repeat (60000) @(posedge i_clk);
		n_mismatch++;
		stop_test();
	end
endmodule : sar_adc_serial_control_test
`default_nettype wire
